// ==== shared/ext_bus_pkg.sv ====
// Constants, field positions and state encodings for the external bus lanes.
// Assumes a 24-bit internal address and a 16-bit external data bus.
package ext_bus_pkg;
   localparam int AREA_CNT = 8;
   localparam int AREA_IDX_W = 3;
   localparam int ADDR_W_DEF = 24;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int LOW_PIN_CNT = 4;
   // Area field positions for the 1-Mbyte and 16-Mbyte address maps
   localparam int AREA_LSB_1M = 17;
   localparam int AREA_LSB_16M = 21;
   // Field encodings
   localparam logic WIDTH_8BIT = 1'b1;
   localparam logic STATES_THREE = 1'b1;
   // Reset values
   localparam logic [AREA_CNT-1:0] CS_IDLE = 8'hFF;
   localparam logic [LOW_PIN_CNT-1:0] DIR_RESET = 4'h0;
   localparam logic [LOW_PIN_CNT-1:0] SEL_EN_RESET = 4'h0;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_T1 = 3'b001,
      ST_T2 = 3'b010,
      ST_TW = 3'b011,
      ST_T3 = 3'b100
   } bus_state_t;
endpackage

// ==== shared/lane_if.sv ====
// Carrier between the bus sequencer and the lane decoder.
// Assumes both ends sit on the same clock; the decoder is purely combinational.
`timescale 1ns/1ps
interface lane_if #(parameter int AW = 24) ();
   logic [AW-1:0] addr;
   logic word;
   logic mode_16m;
   logic [ext_bus_pkg::AREA_CNT-1:0] width_bits;
   logic [ext_bus_pkg::AREA_CNT-1:0] state_bits;
   logic [ext_bus_pkg::AREA_IDX_W-1:0] area;
   logic width8;
   logic three;
   logic use_hi;
   logic use_lo;
   modport seq (output addr, word, mode_16m, width_bits, state_bits,
      input area, width8, three, use_hi, use_lo);
   modport dec (input addr, word, mode_16m, width_bits, state_bits,
      output area, width8, three, use_hi, use_lo);
endinterface

// ==== verilog/lane_decode.sv ====
// Area decode from the access address and map mode; data lane selection also uses access size and area width.
// Assumes address and size are stable while the sequencer samples them.
`timescale 1ns/1ps
module lane_decode #(
   parameter int AW = 24
) (
   lane_if.dec lk
);
   always_comb begin
      // Select is a pure address decode, safe as an SRAM enable
      if (lk.mode_16m) begin
         lk.area = lk.addr[ext_bus_pkg::AREA_LSB_16M +: ext_bus_pkg::AREA_IDX_W];
      end else begin
         lk.area = lk.addr[ext_bus_pkg::AREA_LSB_1M +: ext_bus_pkg::AREA_IDX_W];
      end
      lk.width8 = (lk.width_bits[lk.area] == ext_bus_pkg::WIDTH_8BIT);
      lk.three = (lk.state_bits[lk.area] == ext_bus_pkg::STATES_THREE);
      // Narrow areas always use the upper half; wide areas use both for words and split bytes by address
      lk.use_hi = lk.width8 | lk.word | ~lk.addr[0];
      lk.use_lo = ~lk.width8 & (lk.word | lk.addr[0]);
   end
endmodule

// ==== verilog/ext_bus_lanes.sv ====
// External bus sequencer: area selects, pin directions, strobes and data lanes.
// Assumes one request at a time from the internal bus; pins enter through two flops.
`timescale 1ns/1ps
module ext_bus_lanes #(
   parameter int ADDR_W = ext_bus_pkg::ADDR_W_DEF
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic req_write,
   input wire logic req_word,
   input wire logic [ext_bus_pkg::DATA_W-1:0] req_wdata,
   input wire logic internal_access,
   input wire logic mode_16m,
   input wire logic rom_enabled,
   input wire logic [ext_bus_pkg::AREA_CNT-1:0] area_width_bit,
   input wire logic [ext_bus_pkg::AREA_CNT-1:0] area_state_count_bit,
   input wire logic port_dir_wr,
   input wire logic [ext_bus_pkg::LOW_PIN_CNT-1:0] port_dir_wdata,
   input wire logic upper_select_enable_wr,
   input wire logic [ext_bus_pkg::LOW_PIN_CNT-1:0] upper_select_enable_wdata,
   input wire logic wait_n,
   input wire logic [ext_bus_pkg::DATA_W-1:0] bus_data_in,
   output logic [ext_bus_pkg::AREA_CNT-1:0] area_select_n,
   output logic [ext_bus_pkg::AREA_CNT-1:0] area_select_oe,
   output logic read_strobe_n,
   output logic high_write_strobe_n,
   output logic low_write_strobe_n,
   output logic [ext_bus_pkg::DATA_W-1:0] bus_data_out,
   output logic bus_data_oe_hi,
   output logic bus_data_oe_lo,
   output logic [ext_bus_pkg::DATA_W-1:0] resp_rdata,
   output logic resp_done,
   output logic busy,
   output logic [ext_bus_pkg::LOW_PIN_CNT-1:0] port_dir_reg,
   output logic [ext_bus_pkg::LOW_PIN_CNT-1:0] upper_select_enable_reg
);
   localparam int BW = ext_bus_pkg::BYTE_W;
   localparam int LP = ext_bus_pkg::LOW_PIN_CNT;

   if (ADDR_W < ext_bus_pkg::AREA_LSB_16M + ext_bus_pkg::AREA_IDX_W) begin : g_bad_addr
      $error("ADDR_W too narrow for the area decode");
   end

   typedef struct packed {
      ext_bus_pkg::bus_state_t fsm;
      logic [ext_bus_pkg::AREA_IDX_W-1:0] area;
      logic [ext_bus_pkg::AREA_CNT-1:0] cs_n;
      logic rd_n;
      logic hwr_n;
      logic lwr_n;
      logic [ext_bus_pkg::DATA_W-1:0] dout;
      logic doe_hi;
      logic doe_lo;
      logic [ext_bus_pkg::DATA_W-1:0] rdata;
      logic done;
      logic busy;
      logic fin;
      logic [LP-1:0] dir;
      logic [LP-1:0] sel_en;
      logic strap_done;
      logic wait_s1;
      logic wait_s2;
      logic [ext_bus_pkg::DATA_W-1:0] din_s1;
      logic [ext_bus_pkg::DATA_W-1:0] din_s2;
      logic write;
      logic word;
      logic width8;
      logic three;
      logic use_hi;
      logic use_lo;
   } lanes_state_t;

   localparam lanes_state_t STATE_RESET = '{
      fsm: ext_bus_pkg::ST_IDLE,
      area: '0,
      cs_n: ext_bus_pkg::CS_IDLE,
      rd_n: 1'b1,
      hwr_n: 1'b1,
      lwr_n: 1'b1,
      dout: ext_bus_pkg::DATA_RESET,
      doe_hi: 1'b0,
      doe_lo: 1'b0,
      rdata: ext_bus_pkg::DATA_RESET,
      done: 1'b0,
      busy: 1'b0,
      fin: 1'b0,
      dir: ext_bus_pkg::DIR_RESET,
      sel_en: ext_bus_pkg::SEL_EN_RESET,
      strap_done: 1'b0,
      wait_s1: 1'b1,
      wait_s2: 1'b1,
      din_s1: ext_bus_pkg::DATA_RESET,
      din_s2: ext_bus_pkg::DATA_RESET,
      write: 1'b0,
      word: 1'b0,
      width8: 1'b0,
      three: 1'b0,
      use_hi: 1'b0,
      use_lo: 1'b0
   };

   lanes_state_t st_r;
   lanes_state_t st_nxt;
   logic take;

   lane_if #(.AW(ADDR_W)) lk ();

   assign lk.addr = req_addr;
   assign lk.word = req_word;
   assign lk.mode_16m = mode_16m;
   assign lk.width_bits = area_width_bit;
   assign lk.state_bits = area_state_count_bit;

   lane_decode #(.AW(ADDR_W)) u_dec (
      .lk(lk)
   );

   // No new cycle while the closing capture is still pending
   assign take = (st_r.fsm == ext_bus_pkg::ST_IDLE) && !st_r.fin && req_valid && !internal_access;

   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      // Pin inputs pass two flops before use
      st_nxt.wait_s1 = wait_n;
      st_nxt.wait_s2 = st_r.wait_s1;
      st_nxt.din_s1 = bus_data_in;
      st_nxt.din_s2 = st_r.din_s1;
      // Mode strap is caught one edge after reset release, never under reset
      if (!st_r.strap_done) begin
         st_nxt.strap_done = 1'b1;
         st_nxt.dir = {{(LP-1){1'b0}}, ~rom_enabled};
      end else if (port_dir_wr) begin
         st_nxt.dir = port_dir_wdata;
      end
      if (upper_select_enable_wr) begin
         st_nxt.sel_en = upper_select_enable_wdata;
      end
      case (st_r.fsm)
         ext_bus_pkg::ST_IDLE: begin
            if (req_valid && internal_access && !st_r.fin) begin
               // Internal target: no strobe, no select
               st_nxt.done = 1'b1;
            end else if (take) begin
               st_nxt.fsm = ext_bus_pkg::ST_T1;
               st_nxt.busy = 1'b1;
               st_nxt.area = lk.area;
               st_nxt.cs_n = ~(8'h01 << lk.area);
               st_nxt.write = req_write;
               st_nxt.word = req_word && !lk.width8;
               st_nxt.width8 = lk.width8;
               st_nxt.three = lk.three;
               st_nxt.use_hi = lk.use_hi;
               st_nxt.use_lo = lk.use_lo;
               st_nxt.rd_n = req_write;
               // Byte data sits on both halves; the unused one is don't-care
               if (req_word && !lk.width8) begin
                  st_nxt.dout = req_wdata;
               end else begin
                  st_nxt.dout = {req_wdata[BW-1:0], req_wdata[BW-1:0]};
               end
               st_nxt.doe_hi = req_write;
               st_nxt.doe_lo = req_write && !lk.width8;
            end
         end
         ext_bus_pkg::ST_T1: begin
            st_nxt.fsm = ext_bus_pkg::ST_T2;
            if (st_r.write) begin
               st_nxt.hwr_n = ~st_r.use_hi;
               st_nxt.lwr_n = ~(st_r.use_lo && !st_r.width8);
            end
         end
         ext_bus_pkg::ST_T2: begin
            if (!st_r.three) begin
               st_nxt.fsm = ext_bus_pkg::ST_IDLE;
            end else if (!st_r.wait_s2) begin
               st_nxt.fsm = ext_bus_pkg::ST_TW;
            end else begin
               st_nxt.fsm = ext_bus_pkg::ST_T3;
            end
         end
         ext_bus_pkg::ST_TW: begin
            if (st_r.wait_s2) begin
               st_nxt.fsm = ext_bus_pkg::ST_T3;
            end
         end
         ext_bus_pkg::ST_T3: begin
            st_nxt.fsm = ext_bus_pkg::ST_IDLE;
         end
         default: begin
            st_nxt.fsm = ext_bus_pkg::ST_IDLE;
         end
      endcase
      // Closing state: release every strobe
      if (st_nxt.fsm == ext_bus_pkg::ST_IDLE && st_r.fsm != ext_bus_pkg::ST_IDLE) begin
         st_nxt.cs_n = ext_bus_pkg::CS_IDLE;
         st_nxt.rd_n = 1'b1;
         st_nxt.hwr_n = 1'b1;
         st_nxt.lwr_n = 1'b1;
         st_nxt.doe_hi = 1'b0;
         st_nxt.doe_lo = 1'b0;
         st_nxt.fin = 1'b1;
      end
      // Pin flops lag two edges, so read lanes are taken one edge after the close
      if (st_r.fin) begin
         if (!st_r.write) begin
            if (st_r.word) begin
               st_nxt.rdata = st_r.din_s2;
            end else if (st_r.use_hi) begin
               st_nxt.rdata = {ext_bus_pkg::BYTE_ZERO, st_r.din_s2[2*BW-1:BW]};
            end else begin
               st_nxt.rdata = {ext_bus_pkg::BYTE_ZERO, st_r.din_s2[BW-1:0]};
            end
         end
         st_nxt.fin = 1'b0;
         st_nxt.busy = 1'b0;
         st_nxt.done = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r <= STATE_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Pin direction per select: low four from the port, upper four from the enables
   for (genvar i = 0; i < ext_bus_pkg::AREA_CNT; i++) begin : g_pin
      if (i < LP) begin : g_low
         assign area_select_oe[i] = st_r.dir[i];
      end else begin : g_high
         assign area_select_oe[i] = st_r.sel_en[i-LP];
      end
   end

   assign area_select_n = st_r.cs_n;
   assign read_strobe_n = st_r.rd_n;
   assign high_write_strobe_n = st_r.hwr_n;
   assign low_write_strobe_n = st_r.lwr_n;
   assign bus_data_out = st_r.dout;
   assign bus_data_oe_hi = st_r.doe_hi;
   assign bus_data_oe_lo = st_r.doe_lo;
   assign resp_rdata = st_r.rdata;
   assign resp_done = st_r.done;
   assign busy = st_r.busy;
   assign port_dir_reg = st_r.dir;
   assign upper_select_enable_reg = st_r.sel_en;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence take_two_s;
      take && !lk.three;
   endsequence
   sequence take_three_s;
      take && lk.three;
   endsequence
   sequence short_cycle_s;
      (st_r.fsm == ext_bus_pkg::ST_T1) ##1 (st_r.fsm == ext_bus_pkg::ST_T2) ##1 (st_r.fsm == ext_bus_pkg::ST_IDLE);
   endsequence

   cs_idle_high_a: assert property ((st_r.fsm == ext_bus_pkg::ST_IDLE) |-> (st_r.cs_n == ext_bus_pkg::CS_IDLE))
      else $error("select low outside an external cycle");
   cs_one_area_a: assert property ((st_r.fsm != ext_bus_pkg::ST_IDLE) |-> $onehot(~st_r.cs_n) && !st_r.cs_n[st_r.area])
      else $error("select does not match the accessed area");
   cs_decode_a: assert property (take |=> !area_select_n[$past(lk.area)])
      else $error("select not decoded from address");
   strap_dir_a: assert property ($rose(st_r.strap_done) |-> st_r.dir == {3'b000, ~$past(rom_enabled)})
      else $error("select pin direction wrong after reset");
   narrow_low_a: assert property ((st_r.fsm != ext_bus_pkg::ST_IDLE && st_r.width8) |-> low_write_strobe_n && !bus_data_oe_lo)
      else $error("low lane used in a narrow area");
   read_common_a: assert property (!read_strobe_n |-> high_write_strobe_n && low_write_strobe_n && !bus_data_oe_hi)
      else $error("write strobe or drive during read");
   two_state_a: assert property (take_two_s |=> short_cycle_s)
      else $error("two-state cycle stretched");
   three_state_a: assert property (take_three_s |=> (st_r.fsm == ext_bus_pkg::ST_T1) ##1 (st_r.fsm == ext_bus_pkg::ST_T2) ##1 (st_r.fsm inside {ext_bus_pkg::ST_TW, ext_bus_pkg::ST_T3}))
      else $error("three-state cycle sequence broken");
   word_write_a: assert property ((st_r.fsm == ext_bus_pkg::ST_T2 && st_r.write && st_r.word) |-> !high_write_strobe_n && !low_write_strobe_n)
      else $error("word write missing a strobe");
   odd_byte_a: assert property ((st_r.fsm == ext_bus_pkg::ST_T2 && st_r.write && !st_r.word && !st_r.width8 && st_r.use_lo) |-> high_write_strobe_n && !low_write_strobe_n)
      else $error("odd byte on wrong lane");
   even_byte_a: assert property ((st_r.fsm == ext_bus_pkg::ST_T2 && st_r.write && !st_r.word && !st_r.width8 && st_r.use_hi) |-> !high_write_strobe_n && low_write_strobe_n)
      else $error("even byte on wrong lane");
   narrow_high_a: assert property ((st_r.fsm == ext_bus_pkg::ST_T2 && st_r.write && st_r.width8) |-> !high_write_strobe_n)
      else $error("narrow write without high strobe");
   word_drive_a: assert property ((st_r.fsm != ext_bus_pkg::ST_IDLE && st_r.write && st_r.word) |-> bus_data_oe_hi && bus_data_oe_lo)
      else $error("word write not driving both halves");
   read_no_drive_a: assert property (!read_strobe_n |-> !bus_data_oe_lo)
      else $error("lower half driven during read");
   internal_quiet_a: assert property ((st_r.fsm == ext_bus_pkg::ST_IDLE && !st_r.fin && req_valid && internal_access) |=> resp_done && area_select_n == ext_bus_pkg::CS_IDLE)
      else $error("internal access touched the pins");
   close_done_a: assert property (st_r.fin |=> resp_done && !busy)
      else $error("access not closed after capture");
   upper_enable_a: assert property (upper_select_enable_wr |=> upper_select_enable_reg == $past(upper_select_enable_wdata))
      else $error("upper select enable not written");
   port_dir_a: assert property ((port_dir_wr && st_r.strap_done) |=> port_dir_reg == $past(port_dir_wdata))
      else $error("port direction not written");
endmodule

// ==== sim/ext_mem_model.sv ====
// Far-side memory model: one 16-bit word per area, byte lanes kept apart.
// Assumes a select reaches it only where its pin output enable is set.
`timescale 1ns/1ps
module ext_mem_model (
   input wire logic ref_clk,
   input wire logic [ext_bus_pkg::AREA_CNT-1:0] area_select_n,
   input wire logic [ext_bus_pkg::AREA_CNT-1:0] area_select_oe,
   input wire logic read_strobe_n,
   input wire logic high_write_strobe_n,
   input wire logic low_write_strobe_n,
   input wire logic [ext_bus_pkg::DATA_W-1:0] bus_data_out,
   output logic [ext_bus_pkg::DATA_W-1:0] bus_data_in
);
   logic [15:0] mem [8];
   logic [15:0] last_r = 16'h0000;
   logic [7:0] sel;
   logic [2:0] a;
   assign sel = ~area_select_n & area_select_oe;
   always_comb begin
      a = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (sel[i]) a = 3'(i);
      end
   end
   // Released lines show the inverse of the last value, so stale data cannot pass
   assign bus_data_in = (!read_strobe_n && sel != 8'h00) ? mem[a] : ~last_r;
   initial begin
      for (int i = 0; i < 8; i++) mem[i] = 16'h0000;
   end
   always @(posedge ref_clk) begin
      last_r <= bus_data_in;
      // Each half is taken only under its own strobe; the other half may be junk
      if (sel != 8'h00 && !high_write_strobe_n) mem[a][15:8] <= bus_data_out[15:8];
      if (sel != 8'h00 && !low_write_strobe_n) mem[a][7:0] <= bus_data_out[7:0];
   end
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench: pin directions after reset, then directed and random accesses.
// Assumes the far-side model answers every selected area whose pin is enabled.
`timescale 1ns/1ps
module tb_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0, req_write = 1'b0, req_word = 1'b0, internal_access = 1'b0;
   logic [23:0] req_addr = 24'h000000;
   logic [15:0] req_wdata = 16'h0000;
   logic mode_16m = 1'b0, rom_enabled = 1'b0, wait_n = 1'b1;
   logic [7:0] area_width_bit = 8'h00, area_state_count_bit = 8'h00;
   logic port_dir_wr = 1'b0, upper_select_enable_wr = 1'b0;
   logic [3:0] port_dir_wdata = 4'h0, upper_select_enable_wdata = 4'h0;
   logic [15:0] bus_data_in, bus_data_out, resp_rdata;
   logic [7:0] area_select_n, area_select_oe;
   logic read_strobe_n, high_write_strobe_n, low_write_strobe_n, bus_data_oe_hi, bus_data_oe_lo;
   logic resp_done, busy;
   logic [3:0] port_dir_reg, upper_select_enable_reg;
   logic [15:0] sh [8];
   logic [31:0] seed = 32'hEE3A6A25;
   int n_fail = 0;
   int comparisons = 0;

   ext_bus_lanes #(.ADDR_W(24)) i_ext_bus_lanes (.ref_clk, .rst, .req_valid, .req_addr, .req_write,
      .req_word, .req_wdata, .internal_access, .mode_16m, .rom_enabled, .area_width_bit,
      .area_state_count_bit, .port_dir_wr, .port_dir_wdata, .upper_select_enable_wr,
      .upper_select_enable_wdata, .wait_n, .bus_data_in, .area_select_n, .area_select_oe,
      .read_strobe_n, .high_write_strobe_n, .low_write_strobe_n, .bus_data_out, .bus_data_oe_hi,
      .bus_data_oe_lo, .resp_rdata, .resp_done, .busy, .port_dir_reg, .upper_select_enable_reg);
   ext_mem_model i_ext_mem_model (.ref_clk, .area_select_n, .area_select_oe, .read_strobe_n,
      .high_write_strobe_n, .low_write_strobe_n, .bus_data_out, .bus_data_in);

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Starts on a falling edge; the request drops one cycle later, once taken
   task automatic access(input logic [2:0] ar, input logic wr, input logic wd, input logic od,
         input logic intl, input logic stall);
      logic [23:0] ad;
      logic w8, hi, lo, full;
      logic [7:0] seen;
      logic [3:0] act;
      int cyc;
      int ec;
      ad = 24'(rnd());
      if (mode_16m) ad[23:21] = ar;
      else ad[19:17] = ar;
      ad[0] = od & ~wd;
      w8 = area_width_bit[ar] === ext_bus_pkg::WIDTH_8BIT;
      full = wd & ~w8;
      hi = w8 | wd | ~ad[0];
      lo = ~w8 & (wd | ad[0]);
      seen = 8'h00;
      act = 4'h0;
      cyc = 0;
      req_valid = 1'b1;
      req_addr = ad;
      req_write = wr;
      req_word = wd;
      req_wdata = 16'(rnd());
      internal_access = intl;
      wait_n = ~stall;
      @(negedge ref_clk);
      req_valid = 1'b0;
      while (resp_done !== 1'b1 && cyc < 20) begin
         seen |= ~area_select_n;
         act |= {~high_write_strobe_n, ~low_write_strobe_n, ~read_strobe_n, bus_data_oe_hi | bus_data_oe_lo};
         cyc++;
         if (cyc == 3) wait_n = 1'b1;
         @(negedge ref_clk);
      end
      if (intl) begin
         chk(16'(cyc), 16'h0000);
         chk(16'(seen), 16'h0000);
      end else begin
         // Wait pin lags two flops; released at the third cycle it costs three wait states
         ec = (area_state_count_bit[ar] !== ext_bus_pkg::STATES_THREE) ? 3 : (!stall ? 4 : 7);
         chk(16'(seen), 16'(8'h01 << ar));
         chk(16'(cyc), 16'(ec));
         chk(16'(act), wr ? {12'h000, hi, lo, 2'b01} : 16'h0002);
         if (!wr) chk(resp_rdata, full ? sh[ar] : {8'h00, hi ? sh[ar][15:8] : sh[ar][7:0]});
         if (wr && hi) sh[ar][15:8] = full ? req_wdata[15:8] : req_wdata[7:0];
         if (wr && lo) sh[ar][7:0] = req_wdata[7:0];
      end
   endtask

   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   initial begin
      #50000;
      n_fail++;
      close_out();
   end

   initial begin
      for (int i = 0; i < 8; i++) sh[i] = 16'h0000;
      for (int r = 0; r < 2; r++) begin
         rst = 1'b1;
         rom_enabled = r[0];
         repeat (16) @(negedge ref_clk);
         rst = 1'b0;
         repeat (2) @(negedge ref_clk);
         chk(16'(area_select_oe), {15'h0000, ~rom_enabled});
      end
      for (int i = 0; i < 3; i++) begin
         port_dir_wr = 1'b1;
         upper_select_enable_wr = 1'b1;
         port_dir_wdata = (i == 2) ? 4'hF : 4'(rnd());
         upper_select_enable_wdata = (i == 2) ? 4'hF : 4'(rnd());
         @(negedge ref_clk);
         port_dir_wr = 1'b0;
         upper_select_enable_wr = 1'b0;
         @(negedge ref_clk);
         chk(16'(area_select_oe), {8'h00, upper_select_enable_wdata, port_dir_wdata});
      end
      // Every width, state count, direction, size and lane, writes before reads
      for (int k = 0; k < 32; k++) begin
         area_width_bit = {8{k[4]}};
         area_state_count_bit = {8{k[3]}};
         access(3'(k[4:3]), ~k[2], k[1], k[0], 1'b0, k[0]);
      end
      for (int k = 0; k < 60; k++) begin
         area_width_bit = 8'(rnd());
         area_state_count_bit = 8'(rnd());
         mode_16m = 1'(rnd());
         access(3'(rnd()), 1'(rnd()), 1'(rnd()), 1'(rnd()), 3'(rnd()) == 3'h0, 1'(rnd()));
      end
      close_out();
   end
endmodule
